// ===== src/asp_uart.v
// Asynchronous serial transceiver with FIFOs, flow control and events
`include "asp_defs.vh"
module asp_uart (
	input  wire        mclk_in,
	input  wire        rst_in,
	input  wire [15:0] baud_integer_period_in,
	input  wire        baud_fraction_in,
	input  wire        eight_data_bits_sel_in,
	input  wire        two_stop_bits_sel_in,
	input  wire        parity_enable_sel_in,
	input  wire        odd_parity_sel_in,
	input  wire        flow_control_enable_in,
	input  wire        auto_request_control_in,
	input  wire        soft_request_bit_in,
	input  wire        irq_edge_level_mode_in,
	input  wire        tx_write_in,
	input  wire [7:0]  tx_data_in,
	input  wire        rx_read_in,
	input  wire        dma_rx_pop_in,
	input  wire        rx_dma_reset_in,
	input  wire        rx_buffer_active_in,
	input  wire        tx_buffer_active_in,
	input  wire [15:0] rx_dma_offset_in,
	input  wire        rxd_in,
	input  wire        clear_to_send_n_in,
	output reg         txd_out,
	output reg         request_to_send_n_out,
	output reg  [7:0]  rx_data_out,
	output reg         tx_idle_flag_out,
	output reg         tx_space_flag_out,
	output reg         rx_valid_flag_out,
	output reg         parity_error_flag_out,
	output reg         frame_error_flag_out,
	output reg         rx_overrun_flag_out,
	output reg         cts_state_out,
	output reg  [15:0] rx_error_offset_out,
	output reg         rx_error_valid_out,
	output reg         tx_idle_irq_out,
	output reg         tx_space_irq_out,
	output reg         rx_valid_irq_out,
	output reg         parity_error_irq_out,
	output reg         frame_error_irq_out,
	output reg         rx_overrun_irq_out,
	output reg         tx_buffer_done_irq_out,
	output reg         rx_buffer_done_irq_out
);
// ----------------------------------------------------------------
// Baud tick generator
// ----------------------------------------------------------------
// Tick at 8x bit rate; each eight ticks span 2N+F system clocks.
// Fraction is distributed by lengthening one tick in eight.
reg  [15:0] div_q;
reg  [2:0]  tk_q;
reg         tick_q;
// Residue of 2N/8 lands on tick zero so one bit time totals 2N+F.
wire [15:0] seg_full;
assign seg_full = (tk_q == 3'h0) ?
	((baud_integer_period_in >> 2) + {15'h0000, baud_fraction_in} +
	{13'h0000, baud_integer_period_in[1:0], 1'b0}) :
	(baud_integer_period_in >> 2);
always @(posedge mclk_in) begin
	if (rst_in) begin
		div_q  <= 16'h0000;
		tk_q   <= 3'h0;
		tick_q <= 1'b0;
	end else if (div_q + 16'h0001 >= seg_full) begin
		div_q  <= 16'h0000;
		tk_q   <= tk_q + 3'h1;
		tick_q <= 1'b1;
	end else begin
		div_q  <= div_q + 16'h0001;
		tick_q <= 1'b0;
	end
end
// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
reg [1:0] rxs_q;
reg [1:0] ctss_q;
always @(posedge mclk_in) begin
	if (rst_in) begin
		rxs_q  <= 2'b11;
		ctss_q <= 2'b11;
	end else begin
		rxs_q  <= {rxs_q[0], rxd_in};
		ctss_q <= {ctss_q[0], clear_to_send_n_in};
	end
end
wire rx_s;
wire cts_n_s;
assign rx_s    = rxs_q[1];
assign cts_n_s = ctss_q[1];
// ----------------------------------------------------------------
// FIFOs
// ----------------------------------------------------------------
reg [7:0]              txm_q [0:3];
reg [`ASP_ENT_W-1:0]   rxm_q [0:3];
reg [1:0] tw_q, tr_q, rw_q, rr_q;
reg [2:0] tc_q, rc_q;
wire tx_full  = (tc_q == `ASP_FIFO_DEPTH);
wire rx_full  = (rc_q == `ASP_FIFO_DEPTH);
wire tx_push  = tx_write_in && !tx_full;
wire rx_pop   = (rx_read_in || dma_rx_pop_in) && (rc_q != 3'h0);
wire tx_pop;
wire rx_push;
wire rx_lost;
wire [`ASP_ENT_W-1:0] rx_entry;
always @(posedge mclk_in) begin
	if (rst_in) begin
		tw_q <= 2'h0;
		tr_q <= 2'h0;
		tc_q <= 3'h0;
		rw_q <= 2'h0;
		rr_q <= 2'h0;
		rc_q <= 3'h0;
	end else begin
		if (tx_push) begin
			txm_q[tw_q] <= tx_data_in;
			tw_q        <= tw_q + 2'h1;
		end
		if (tx_pop)
			tr_q <= tr_q + 2'h1;
		tc_q <= tc_q + {2'h0, tx_push} - {2'h0, tx_pop};
		if (rx_push) begin
			rxm_q[rw_q] <= rx_entry;
			rw_q        <= rw_q + 2'h1;
		end
		if (rx_pop)
			rr_q <= rr_q + 2'h1;
		rc_q <= rc_q + {2'h0, rx_push} - {2'h0, rx_pop};
	end
end
// ----------------------------------------------------------------
// Transmitter
// ----------------------------------------------------------------
localparam TX_IDLE = 1'b0;
localparam TX_SEND = 1'b1;
reg        tst_q;
reg [11:0] tsh_q;
reg [3:0]  tbits_q;
reg [2:0]  tph_q;
wire [7:0] tx_head = txm_q[tr_q];
wire [7:0] tx_dmask = eight_data_bits_sel_in ? tx_head : {1'b0, tx_head[6:0]};
wire       tx_par = (^tx_dmask) ^ odd_parity_sel_in;
wire       cts_ok = !flow_control_enable_in || !cts_n_s;
wire       tx_go  = (tst_q == TX_IDLE) && (tc_q != 3'h0) && cts_ok && tick_q;
assign tx_pop = tx_go;
// Frame bits assembled once; shifted LSB first behind the start bit
reg [11:0] tx_frame;
reg [3:0]  tx_len;
always @* begin
	tx_frame = 12'hFFF;
	tx_len   = 4'h0;
	if (eight_data_bits_sel_in) begin
		tx_frame[8:0] = {tx_head, 1'b0};
		tx_frame[9]   = parity_enable_sel_in ? tx_par : 1'b1;
		tx_len = 4'h9 + {3'h0, parity_enable_sel_in}
			+ {3'h0, two_stop_bits_sel_in} + 4'h1;
	end else begin
		tx_frame[7:0] = {tx_head[6:0], 1'b0};
		tx_frame[8]   = parity_enable_sel_in ? tx_par : 1'b1;
		tx_len = 4'h8 + {3'h0, parity_enable_sel_in}
			+ {3'h0, two_stop_bits_sel_in} + 4'h1;
	end
end
always @(posedge mclk_in) begin
	if (rst_in) begin
		tst_q   <= TX_IDLE;
		tsh_q   <= 12'hFFF;
		tbits_q <= 4'h0;
		tph_q   <= 3'h0;
		txd_out <= 1'b1;
	end else begin
		case (tst_q)
		TX_IDLE: begin
			txd_out <= 1'b1;
			if (tx_go) begin
				tst_q   <= TX_SEND;
				tsh_q   <= tx_frame;
				tbits_q <= tx_len;
				tph_q   <= 3'h0;
			end
		end
		TX_SEND: begin
			// Clear-to-send is not looked at here: the frame runs out
			txd_out <= tsh_q[0];
			if (tick_q) begin
				tph_q <= tph_q + 3'h1;
				if (tph_q == 3'h7) begin
					tsh_q   <= {1'b1, tsh_q[11:1]};
					tbits_q <= tbits_q - 4'h1;
					if (tbits_q == 4'h1)
						tst_q <= TX_IDLE;
				end
			end
		end
		default: tst_q <= TX_IDLE;
		endcase
	end
end
// ----------------------------------------------------------------
// Receiver
// ----------------------------------------------------------------
localparam RX_IDLE  = 2'h0;
localparam RX_START = 2'h1;
localparam RX_BITS  = 2'h2;
reg [1:0] rst_q;
reg [7:0] rph_q;
reg [3:0] rcnt_q;
reg [9:0] rsh_q;
reg       rpush_q;
reg       rlost_q;
reg       rprev_q;
wire [3:0] rx_need = (eight_data_bits_sel_in ? 4'h9 : 4'h8)
	+ {3'h0, parity_enable_sel_in};
always @(posedge mclk_in) begin
	if (rst_in) begin
		rst_q   <= RX_IDLE;
		rph_q   <= 8'h00;
		rcnt_q  <= 4'h0;
		rsh_q   <= 10'h000;
		rpush_q <= 1'b0;
		rlost_q <= 1'b0;
		rprev_q <= 1'b1;
	end else begin
		rpush_q <= 1'b0;
		rlost_q <= 1'b0;
		if (tick_q)
			rprev_q <= rx_s;
		case (rst_q)
		RX_IDLE: if (tick_q && !rx_s && rprev_q) begin
			rst_q <= RX_START;
			rph_q <= 8'h01;
		end
		RX_START: if (tick_q) begin
			rph_q <= rph_q + 8'h01;
			if (rph_q == `ASP_OVS_HALF - 8'h01) begin
				// False start filtered: line must still be low mid-bit
				rst_q  <= rx_s ? RX_IDLE : RX_BITS;
				rph_q  <= 8'h00;
				rcnt_q <= 4'h0;
			end
		end
		RX_BITS: if (tick_q) begin
			rph_q <= rph_q + 8'h01;
			if (rph_q == `ASP_OVS - 8'h01) begin
				rph_q  <= 8'h00;
				rsh_q  <= {rx_s, rsh_q[9:1]};
				rcnt_q <= rcnt_q + 4'h1;
				if (rcnt_q == rx_need - 4'h1) begin
					rst_q   <= RX_IDLE;
					rpush_q <= !rx_full;
					rlost_q <= rx_full;
				end
			end
		end
		default: rst_q <= RX_IDLE;
		endcase
	end
end
// Shift register holds data, optional parity, stop at top bit
reg [7:0] rx_d;
reg       rx_pbit;
always @* begin
	rx_pbit = rsh_q[8];
	if (eight_data_bits_sel_in) begin
		rx_d    = parity_enable_sel_in ? rsh_q[7:0] : rsh_q[8:1];
	end else begin
		rx_d    = parity_enable_sel_in ? {1'b0, rsh_q[7:1]}
			: {1'b0, rsh_q[8:2]};
	end
end
wire rx_pe = parity_enable_sel_in &&
	((^rx_d) ^ odd_parity_sel_in ^ rx_pbit);
wire rx_fe = !rsh_q[9];
assign rx_push  = rpush_q;
assign rx_lost  = rlost_q;
assign rx_entry = {rx_fe, rx_pe, rx_d};
// ----------------------------------------------------------------
// Status, request line, error offset and events
// ----------------------------------------------------------------
wire [`ASP_ENT_W-1:0] rx_head = rxm_q[rr_q];
wire [`ASP_ENT_W-1:0] next_head = (rx_pop && !(rc_q == 3'h1 && rx_push)) ?
	rxm_q[rr_q + 2'h1] : rx_entry;
wire [2:0] rc_next = rc_q + {2'h0, rx_push} - {2'h0, rx_pop};
wire idle_d  = (tc_q == 3'h0) && (tst_q == TX_IDLE) && !tx_push;
wire space_d = (tc_q + {2'h0, tx_push} - {2'h0, tx_pop}) != `ASP_FIFO_DEPTH;
wire valid_d = rc_next != 3'h0;
wire [2:0] room = `ASP_FIFO_DEPTH - rc_next;
reg  tx_act_q;
reg  rx_act_q;
wire head_err = rx_head[`ASP_ENT_PE] || rx_head[`ASP_ENT_FE];
always @(posedge mclk_in) begin
	if (rst_in) begin
		request_to_send_n_out  <= 1'b1;
		rx_data_out            <= 8'h00;
		tx_idle_flag_out       <= 1'b1;
		tx_space_flag_out      <= 1'b1;
		rx_valid_flag_out      <= 1'b0;
		parity_error_flag_out  <= 1'b0;
		frame_error_flag_out   <= 1'b0;
		rx_overrun_flag_out    <= 1'b0;
		cts_state_out          <= 1'b0;
		rx_error_offset_out    <= `ASP_OFS_NONE;
		rx_error_valid_out     <= 1'b0;
		tx_idle_irq_out        <= 1'b0;
		tx_space_irq_out       <= 1'b0;
		rx_valid_irq_out       <= 1'b0;
		parity_error_irq_out   <= 1'b0;
		frame_error_irq_out    <= 1'b0;
		rx_overrun_irq_out     <= 1'b0;
		tx_buffer_done_irq_out <= 1'b0;
		rx_buffer_done_irq_out <= 1'b0;
		tx_act_q               <= 1'b0;
		rx_act_q               <= 1'b0;
	end else begin
		if (!flow_control_enable_in)
			request_to_send_n_out <= 1'b1;
		else if (auto_request_control_in)
			request_to_send_n_out <= !(room >= `ASP_RTS_ROOM);
		else
			request_to_send_n_out <= !soft_request_bit_in;
		cts_state_out <= !cts_n_s;
		// Head character and its flags follow every pop
		if (rx_pop || (rc_q == 3'h0 && rx_push)) begin
			rx_data_out           <= next_head[7:0];
			parity_error_flag_out <= next_head[`ASP_ENT_PE];
			frame_error_flag_out  <= next_head[`ASP_ENT_FE];
		end
		if (!valid_d) begin
			parity_error_flag_out <= 1'b0;
			frame_error_flag_out  <= 1'b0;
		end
		// Set wins over a read in the same cycle
		if (rx_lost)
			rx_overrun_flag_out <= 1'b1;
		else if (rx_read_in)
			rx_overrun_flag_out <= 1'b0;
		tx_idle_flag_out  <= idle_d;
		tx_space_flag_out <= space_d;
		rx_valid_flag_out <= valid_d;
		// Level mode repeats while high; edge mode pulses on the rise
		tx_idle_irq_out  <= idle_d &&
			(irq_edge_level_mode_in || !tx_idle_flag_out);
		tx_space_irq_out <= space_d &&
			(irq_edge_level_mode_in || !tx_space_flag_out);
		rx_valid_irq_out <= valid_d &&
			(irq_edge_level_mode_in || !rx_valid_flag_out);
		parity_error_irq_out <= rx_push && rx_entry[`ASP_ENT_PE];
		frame_error_irq_out  <= rx_push && rx_entry[`ASP_ENT_FE];
		rx_overrun_irq_out   <= rx_lost;
		tx_act_q <= tx_buffer_active_in;
		rx_act_q <= rx_buffer_active_in;
		tx_buffer_done_irq_out <= tx_act_q && !tx_buffer_active_in;
		rx_buffer_done_irq_out <= rx_act_q && !rx_buffer_active_in;
		// First error wins; clear by reset or reload, record wins over clear
		if (!rx_error_valid_out && dma_rx_pop_in && rx_pop && head_err) begin
			rx_error_valid_out  <= 1'b1;
			rx_error_offset_out <= rx_dma_offset_in;
		end else if (!rx_error_valid_out && rx_lost) begin
			rx_error_valid_out  <= 1'b1;
			rx_error_offset_out <= rx_dma_offset_in + `ASP_OVF_AHEAD;
		end else if (rx_dma_reset_in || (rx_buffer_active_in && !rx_act_q)) begin
			rx_error_valid_out  <= 1'b0;
			rx_error_offset_out <= `ASP_OFS_NONE;
		end
	end
end
endmodule

// ===== src/asp_defs.vh
// Constants for the asynchronous serial port with FIFOs and flow control
// Contract
// - Bit clock is system clock divided by 2N+F.
// - Seven data bits when eight-bit select clear, else eight.
// - Transmit one or two stop bits; receiver needs only one.
// - Parity bit sent and expected only when parity enabled.
// - Even parity is XOR of data; odd is inverse; ignored without parity.
// - Frame is start, data LSB first, parity, stops: 9 to 12 bits.
// - Lines idle high; a start bit is the line falling low.
// - Four-entry transmit and receive FIFOs; write pushes, read pops.
// - DMA pushes and pops the FIFOs exactly like software; a DMA pop does not clear the overrun flag, only a data read does.
// - With flow control, new character starts only while clear-to-send low.
// - Character in progress finishes even if clear-to-send rises.
// - Auto request drives request low when two or more FIFO slots free.
// - Without auto, request follows the software request bit.
// - Flow control off: request and clear-to-send take no part.
// - DMA records offset of first parity or frame errored character.
// - Overrun flagged at once; offset recorded four characters beyond.
// - Error offset indication clears on DMA reset or buffer reload.
// - Idle, space, valid interrupts fire on rising edge or high level.
// - Buffer-complete interrupts fire on active flag falling.
// - Interrupts for parity error, frame error and overrun.
// - Parity/frame status describe head character; cleared when FIFO empty.
// - Overrun sets on byte into full FIFO; clears on data read.
// - Transmit idle only when FIFO and shift register both empty.
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
`define ASP_OVS        8'h08
`define ASP_OVS_HALF   8'h04
`define ASP_FIFO_DEPTH 3'h4
`define ASP_RTS_ROOM   3'h2
`define ASP_OVF_AHEAD  16'h0004
`define ASP_PER_MIN    16'h0008
`define ASP_OFS_NONE   16'hFFFF
`define ASP_ENT_W      10
`define ASP_ENT_PE     8
`define ASP_ENT_FE     9
`endif

// ===== sim/asp_uart_assertions.sv
// Concurrent checks on the serial port outputs
module asp_uart_assertions (
	input logic mclk_in,
	input logic rst_in,
	input logic flow_control_enable_in,
	input logic auto_request_control_in,
	input logic soft_request_bit_in,
	input logic irq_edge_level_mode_in,
	input logic clear_to_send_n_in,
	input logic rx_read_in,
	input logic rx_dma_reset_in,
	input logic dma_rx_pop_in,
	input logic rx_buffer_active_in,
	input logic tx_buffer_active_in,
	input logic txd_out,
	input logic request_to_send_n_out,
	input logic tx_idle_flag_out,
	input logic rx_valid_flag_out,
	input logic parity_error_flag_out,
	input logic frame_error_flag_out,
	input logic rx_overrun_flag_out,
	input logic cts_state_out,
	input logic rx_error_valid_out,
	input logic tx_idle_irq_out,
	input logic rx_valid_irq_out,
	input logic rx_overrun_irq_out,
	input logic rx_buffer_done_irq_out,
	input logic tx_buffer_done_irq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	// Pin is synchronised, so it must settle for a few cycles first
	sequence s_cts_on;
		(!clear_to_send_n_in) [*4];
	endsequence
	sequence s_cts_off;
		clear_to_send_n_in [*4];
	endsequence
	sequence s_idle_level;
		(irq_edge_level_mode_in && tx_idle_flag_out) [*3];
	endsequence
	chk_idle_line_high: assert property (tx_idle_flag_out |-> txd_out)
		else $error("line low while transmitter idle");
	chk_cts_state_on: assert property (s_cts_on |-> cts_state_out)
		else $error("clear-to-send state not asserted");
	chk_cts_state_off: assert property (s_cts_off |-> !cts_state_out)
		else $error("clear-to-send state not released");
	chk_soft_request: assert property (flow_control_enable_in &&
		!auto_request_control_in |=>
		request_to_send_n_out == !$past(soft_request_bit_in))
		else $error("request line does not follow software bit");
	chk_overrun_flag: assert property (rx_overrun_irq_out |->
		##[0:1] rx_overrun_flag_out)
		else $error("overrun interrupt without overrun status");
	chk_overrun_read: assert property (rx_read_in |=>
		!rx_overrun_flag_out || rx_overrun_irq_out)
		else $error("overrun status kept after data read");
	chk_empty_flags: assert property (!rx_valid_flag_out |->
		!parity_error_flag_out && !frame_error_flag_out)
		else $error("error status set with empty receive fifo");
	chk_edge_irq: assert property (rx_valid_irq_out &&
		!$past(irq_edge_level_mode_in) |->
		rx_valid_flag_out && !$past(rx_valid_flag_out))
		else $error("edge interrupt without rising flag");
	chk_level_irq: assert property (s_idle_level |-> tx_idle_irq_out)
		else $error("level interrupt missing while idle");
	chk_rx_done_irq: assert property ($fell(rx_buffer_active_in) |->
		##[0:3] rx_buffer_done_irq_out)
		else $error("receive buffer done interrupt missing");
	chk_tx_done_irq: assert property ($fell(tx_buffer_active_in) |->
		##[0:3] tx_buffer_done_irq_out)
		else $error("transmit buffer done interrupt missing");
	chk_err_clear: assert property (rx_dma_reset_in &&
		!dma_rx_pop_in |=> !rx_error_valid_out || rx_overrun_irq_out)
		else $error("error offset kept after dma reset");
endmodule
bind asp_uart asp_uart_assertions asp_uart_assertions_i (.*);

// ===== sim/asp_serial_peer.sv
// Behavioural far-end serial device
module asp_serial_peer #(
	parameter int BT = 16
) (
	input  logic       mclk_in,
	input  logic       txd_in,
	input  logic [3:0] len_in,
	output logic       rxd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] cap_q;
	int          cap_n = 0;
	initial rxd_out = 1'b1;
	// Bits after the start bit go out LSB first
	task automatic send(input logic [11:0] bits, input int n);
		rxd_out = 1'b0;
		repeat (BT) @(negedge mclk_in);
		for (int i = 0; i < n; i++) begin
			rxd_out = bits[i];
			repeat (BT) @(negedge mclk_in);
		end
		rxd_out = 1'b1;
	endtask
	// Centre sampling; tolerates a bit time off by a few clocks
	always begin
		@(negedge txd_in);
		cap_q = 12'hFFF;
		repeat (BT / 2) @(posedge mclk_in);
		for (int i = 0; i < len_in; i++) begin
			repeat (BT) @(posedge mclk_in);
			cap_q[i] = txd_in;
		end
		cap_n++;
	end
endmodule

// ===== sim/asp_uart_bench.sv
// Self-checking bench for the serial port
module asp_uart_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BT = 2 * 8 + 0;
	logic        mclk_in, rst_in, baud_fraction_in, flow_control_enable_in;
	logic        auto_request_control_in, soft_request_bit_in, tx_write_in;
	logic        irq_edge_level_mode_in, rx_read_in, dma_rx_pop_in, rxd_in;
	logic        rx_dma_reset_in, rx_buffer_active_in, tx_buffer_active_in;
	logic        clear_to_send_n_in, eight_data_bits_sel_in;
	logic        two_stop_bits_sel_in, parity_enable_sel_in, odd_parity_sel_in;
	logic        txd_out, request_to_send_n_out, tx_idle_flag_out;
	logic        tx_space_flag_out, rx_valid_flag_out, parity_error_flag_out;
	logic        frame_error_flag_out, rx_overrun_flag_out, cts_state_out;
	logic        rx_error_valid_out, tx_idle_irq_out, tx_space_irq_out;
	logic        rx_valid_irq_out, parity_error_irq_out, frame_error_irq_out;
	logic        rx_overrun_irq_out, tx_buffer_done_irq_out;
	logic        rx_buffer_done_irq_out;
	logic [7:0]  tx_data_in, rx_data_out;
	logic [15:0] baud_integer_period_in, rx_dma_offset_in, rx_error_offset_out;
	logic [3:0]  cfg, len;
	int          fail_count, n_tests, k, in_n, pe_n, fe_n, ov_n, rv_n, rd_n, td_n;
	int          sp_n;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic int flen(logic [3:0] c);
		return 8 + c[0] + c[1] + c[3];
	endfunction
	function automatic logic [11:0] fbits(logic [7:0] d, logic [3:0] c,
		logic bp);
		logic [11:0] b;
		logic        p;
		b = 12'hFFF;
		p = c[2] ^ bp;
		for (int i = 0; i < 7 + c[0]; i++) begin
			b[i] = d[i];
			p = p ^ d[i];
		end
		if (c[1]) b[7 + c[0]] = p;
		return b;
	endfunction
	assign {two_stop_bits_sel_in, odd_parity_sel_in} = cfg[3:2];
	assign {parity_enable_sel_in, eight_data_bits_sel_in} = cfg[1:0];
	assign len = 4'(flen(cfg));
	always #12.5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) if (!rst_in) begin
		in_n += tx_idle_irq_out;
		sp_n += tx_space_irq_out;
		pe_n += parity_error_irq_out;
		fe_n += frame_error_irq_out;
		ov_n += rx_overrun_irq_out;
		rv_n += rx_valid_irq_out;
		rd_n += rx_buffer_done_irq_out;
		td_n += tx_buffer_done_irq_out;
	end
	asp_uart asp_uart_i (.*);
	asp_serial_peer #(.BT(BT)) asp_serial_peer_i (.mclk_in(mclk_in),
		.txd_in(txd_out), .len_in(len), .rxd_out(rxd_in));
	task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask
	task automatic wr(logic [7:0] d);
		tx_data_in = d;
		pulse(tx_write_in);
	endtask
	task automatic wait_idle();
		tick(3);
		for (int i = 0; i < 3000 && tx_idle_flag_out !== 1'b1; i++) tick(1);
		tick(4);
	endtask
	task automatic rxc(logic [7:0] d, logic bp, logic bf);
		asp_serial_peer_i.send(fbits(d, cfg, bp) & ~(12'(bf) << (len - 1)),
			len);
		tick(2 * BT);
	endtask
	task automatic head(logic [15:0] e);
		cmp("rx_head", e, {6'h00, parity_error_flag_out, frame_error_flag_out,
			rx_data_out});
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (60000) @(posedge mclk_in);
		fail_count++;
		$display("CHECK FAILED watchdog expected finish seen timeout");
		stop_test();
	end
	initial begin
		{mclk_in, baud_fraction_in, flow_control_enable_in, tx_write_in} = 0;
		{auto_request_control_in, soft_request_bit_in, rx_read_in} = 0;
		{irq_edge_level_mode_in, dma_rx_pop_in, rx_dma_reset_in} = 0;
		{rx_buffer_active_in, tx_buffer_active_in, tx_data_in, cfg} = 0;
		baud_integer_period_in = 16'h0008;
		rx_dma_offset_in = 16'h0010;
		clear_to_send_n_in = 1'b1;
		rst_in = 1'b1;
		tick(16);
		rst_in = 1'b0;
		tick(2);
		cmp("reset_flags", 16'h0078, {txd_out, request_to_send_n_out,
			tx_idle_flag_out, tx_space_flag_out, rx_valid_flag_out,
			rx_overrun_flag_out, rx_error_valid_out});
		cmp("reset_offset", 16'hFFFF, rx_error_offset_out);
		$display("test reset done");
		// Every frame format, with clear-to-send held off and flow disabled
		k = in_n;
		tx_buffer_active_in = 1'b1;
		for (int c = 0; c < 16; c++) begin
			cfg = c[3:0];
			wr(8'h5A ^ {cfg, cfg});
			cmp("tx_busy", 0, tx_idle_flag_out);
			wait_idle();
			cmp("tx_frames", 16'(c + 1), 16'(asp_serial_peer_i.cap_n));
			cmp("tx_bits", fbits(8'h5A ^ {cfg, cfg}, cfg, 1'b0),
				asp_serial_peer_i.cap_q);
		end
		cmp("idle_edge_irqs", 16, 16'(in_n - k));
		$display("test formats done");
		flow_control_enable_in = 1'b1;
		soft_request_bit_in = 1'b1;
		tick(3);
		cmp("rts_soft_on", 0, request_to_send_n_out);
		soft_request_bit_in = 1'b0;
		tick(3);
		cmp("rts_soft_off", 1, request_to_send_n_out);
		cfg = 4'h1;
		k = asp_serial_peer_i.cap_n;
		wr(8'hC3);
		wr(8'h3C);
		wr(8'h81);
		wr(8'h7E);
		wr(8'hFF);
		cmp("tx_full", 0, tx_space_flag_out);
		tick(100);
		cmp("cts_held", 16'(k), 16'(asp_serial_peer_i.cap_n));
		clear_to_send_n_in = 1'b0;
		for (int i = 0; i < 300 && txd_out !== 1'b0; i++) tick(1);
		clear_to_send_n_in = 1'b1;
		tick(600);
		cmp("cts_finish", 16'(k + 1), 16'(asp_serial_peer_i.cap_n));
		cmp("cts_bits", fbits(8'hC3, cfg, 1'b0), asp_serial_peer_i.cap_q);
		clear_to_send_n_in = 1'b0;
		wait_idle();
		cmp("cts_resume", fbits(8'h7E, cfg, 1'b0), asp_serial_peer_i.cap_q);
		cmp("tx_drop", 16'(k + 4), 16'(asp_serial_peer_i.cap_n));
		cmp("space_irq", 1, 16'(sp_n));
		$display("test flow done");
		// Receive path: errors, automatic request, overrun and dma marking
		cfg = 4'h3;
		auto_request_control_in = 1'b1;
		rx_buffer_active_in = 1'b1;
		rxc(8'h3C, 1'b0, 1'b0);
		rxc(8'h5A, 1'b1, 1'b0);
		cmp("rts_room_two", 0, request_to_send_n_out);
		rxc(8'h66, 1'b0, 1'b1);
		cmp("rts_room_one", 1, request_to_send_n_out);
		rxc(8'h81, 1'b0, 1'b0);
		rxc(8'h99, 1'b0, 1'b0);
		cmp("overrun", 1, rx_overrun_flag_out);
		cmp("ovf_irq", 1, 16'(ov_n));
		cmp("ovf_offset", 16'h0014, rx_error_offset_out);
		cmp("ovf_marked", 1, rx_error_valid_out);
		pulse(rx_dma_reset_in);
		cmp("mark_reset", 0, rx_error_valid_out);
		head(16'h003C);
		rx_dma_offset_in = 16'h0020;
		pulse(dma_rx_pop_in);
		cmp("mark_good", 0, rx_error_valid_out);
		head(16'h025A);
		rx_dma_offset_in = 16'h0021;
		pulse(dma_rx_pop_in);
		cmp("mark_parity", 16'h0021, rx_error_offset_out);
		head(16'h0166);
		pulse(rx_read_in);
		cmp("ovf_read", 0, rx_overrun_flag_out);
		head(16'h0081);
		pulse(rx_read_in);
		cmp("rx_empty", 0, {rx_valid_flag_out, parity_error_flag_out,
			frame_error_flag_out});
		cmp("err_irqs", 3, {pe_n > 0, fe_n > 0});
		cmp("valid_irq", 1, 16'(rv_n > 0));
		cmp("mark_kept", 1, rx_error_valid_out);
		rx_buffer_active_in = 1'b0;
		tx_buffer_active_in = 1'b0;
		tick(4);
		cmp("done_irqs", 16'h0101, {8'(rd_n), 8'(td_n)});
		rx_buffer_active_in = 1'b1;
		tick(4);
		cmp("mark_reload", 0, rx_error_valid_out);
		k = in_n;
		irq_edge_level_mode_in = 1'b1;
		tick(10);
		irq_edge_level_mode_in = 1'b0;
		cmp("idle_level_irq", 1, 16'(in_n - k >= 8));
		$display("test receive done");
		stop_test();
	end
endmodule
